// ---- design/led_ctrl_pkg.sv ----
// Types shared by the LED control block and its serial register port.
`default_nettype none
package led_ctrl_pkg;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // Sink order: [3:0] main dedicated, [4] secondary dedicated,
  // [5] assignable one, [6] assignable two, [7] indicator.
  typedef struct packed {
    logic [7:0] sink_on;
    logic [1:0] assign_in_main;
    logic [4:0] main_code;
    logic [2:0] sec_code;
    logic [2:0] ind_code;
  } sink_drive_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_DEV = 3'b001,
    PS_PTR = 3'b010,
    PS_WDATA = 3'b011,
    PS_RDATA = 3'b100
  } port_state_t;

endpackage
`default_nettype wire

// ---- design/led_ctrl_regs.svh ----
// Register offsets, reset values, field positions and timing counts of the LED control block.
`ifndef LED_CTRL_REGS_SVH
`define LED_CTRL_REGS_SVH

`define DEV_ADDR 7'h36

`define REG_GENERAL 8'h10
`define REG_MAIN_LEVEL 8'hA0
`define REG_SEC_LEVEL 8'hB0
`define REG_IND_LEVEL 8'hC0
`define REG_RAMP_STEP 8'h20
`define REG_VF_DELAY 8'h60

`define RST_GENERAL 8'h00
`define RST_MAIN_LEVEL 8'hE0
`define RST_SEC_LEVEL 8'hF8
`define RST_IND_LEVEL 8'hF8
`define RST_RAMP_STEP 8'hF0
`define RST_VF_DELAY 8'hFC

`define GP_MAIN_ON 0
`define GP_SEC_ON 1
`define GP_IND_ON 2
`define GP_SD_ONE 3
`define GP_SD_TWO 4
`define GP_ONE_MAIN 5
`define GP_TWO_MAIN 6
`define RS_BUSY 2

`define MCLK_PERIOD_NS 50
`define STEP_100US_NS 100000
`define STEP_25MS_NS 25000000
`define STEP_50MS_NS 50000000
`define STEP_100MS_NS 100000000
`define STEP_100US_CYC (`STEP_100US_NS / `MCLK_PERIOD_NS)
`define STEP_25MS_CYC (`STEP_25MS_NS / `MCLK_PERIOD_NS)
`define STEP_50MS_CYC (`STEP_50MS_NS / `MCLK_PERIOD_NS)
`define STEP_100MS_CYC (`STEP_100MS_NS / `MCLK_PERIOD_NS)

`endif

// ---- design/led_group_assign_ramp_ctrl.sv ----
// LED sink grouping, brightness registers and main group current ramp.
//
// Summary of operation
// - Eight sinks form main, secondary, indicator groups.
// - Main four sinks, others one, two assignable.
// - Assignment bit one means main, zero secondary.
// - Reset gives four main, three secondary, one indicator.
// - Indicator group is always exactly one sink.
// - Main group has 32 current codes.
// - Secondary and indicator have 8 codes each.
// - Brightness settings arrive as serial register writes.
// - Only the main group ramps; others change directly.
// - Ramp target is the main level register.
// - Step field picks 100us, 25ms, 50ms, 100ms.
// - Enable steps up, disable steps down, no jumps.
// - Ramp time is levels crossed times step.
// - Shutdown bit fully disables its assignable sink.
// - Separate enables for main, secondary and indicator.
// - Main code is five low bits, all ones full.
// - Three-bit codes give 10 to 70, then 100 percent.
`include "led_ctrl_regs.svh"
`default_nettype none
module led_group_assign_ramp_ctrl
  import led_ctrl_pkg::*;
#(
  parameter int STEP_25MS_CYC = `STEP_25MS_CYC,
  parameter int STEP_50MS_CYC = `STEP_50MS_CYC,
  parameter int STEP_100MS_CYC = `STEP_100MS_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output sink_drive_t drive
);

  localparam int STEP_100US_CYC = `STEP_100US_CYC;

  generate
    if (STEP_25MS_CYC < 1 || STEP_50MS_CYC < 1 || STEP_100MS_CYC < 1 ||
        STEP_25MS_CYC >= 2**22 || STEP_50MS_CYC >= 2**22 || STEP_100MS_CYC >= 2**22) begin : g_bad
      $error("Step counts must lie between 1 and 2**22-1.");
    end
  endgenerate

  reg_wr_t wr;
  logic [7:0] rd_ptr;
  logic [7:0] rd_data;
  logic [7:0] gp_ff;
  logic [4:0] tgt_ff;
  logic [2:0] sec_ff;
  logic [2:0] ind_ff;
  logic [1:0] rs_ff;
  logic [1:0] vf_ff;
  logic [4:0] cur_ff;
  logic [21:0] step_cnt_ff;
  logic main_active_ff;
  sink_drive_t drive_ff;
  sink_drive_t nxt_drive;
  logic [4:0] goal;
  logic [21:0] step_last;
  logic tick;
  logic main_on;

  serial_reg_port u_port (
    .mclk(mclk),
    .rst(rst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .wr(wr),
    .rd_ptr(rd_ptr),
    .rd_data(rd_data)
  );

  // Open-drain data line: only ever pulled low.
  assign sda_out = 1'b0;

  // Register writes; bits without storage read back as in the reset image, except the ramp busy flag.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gp_ff <= `RST_GENERAL;
      tgt_ff <= 5'(`RST_MAIN_LEVEL & 8'h1F);
      sec_ff <= 3'(`RST_SEC_LEVEL & 8'h07);
      ind_ff <= 3'(`RST_IND_LEVEL & 8'h07);
      rs_ff <= 2'(`RST_RAMP_STEP & 8'h03);
      vf_ff <= 2'(`RST_VF_DELAY & 8'h03);
    end else if (wr.valid) begin
      unique case (wr.addr)
        `REG_GENERAL: gp_ff <= {1'b0, wr.data[6:0]};
        `REG_MAIN_LEVEL: tgt_ff <= wr.data[4:0];
        `REG_SEC_LEVEL: sec_ff <= wr.data[2:0];
        `REG_IND_LEVEL: ind_ff <= wr.data[2:0];
        `REG_RAMP_STEP: rs_ff <= wr.data[1:0];
        `REG_VF_DELAY: vf_ff <= wr.data[1:0];
        default: begin
        end
      endcase
    end
  end

  // Readback of the addressed register; the ramp step register reports a busy ramp.
  always_comb begin
    unique case (rd_ptr)
      `REG_GENERAL: rd_data = gp_ff;
      `REG_MAIN_LEVEL: rd_data = {3'h7, tgt_ff};
      `REG_SEC_LEVEL: rd_data = {5'h1F, sec_ff};
      `REG_IND_LEVEL: rd_data = {5'h1F, ind_ff};
      `REG_RAMP_STEP: rd_data = {4'hF, 1'b0, cur_ff != goal, rs_ff};
      `REG_VF_DELAY: rd_data = {6'h3F, vf_ff};
      default: rd_data = 8'h00;
    endcase
  end

  assign main_on = gp_ff[`GP_MAIN_ON];
  assign goal = main_on ? tgt_ff : 5'h00;

  always_comb begin
    unique case (rs_ff)
      2'b00: step_last = 22'(STEP_100US_CYC - 1);
      2'b01: step_last = 22'(STEP_25MS_CYC - 1);
      2'b10: step_last = 22'(STEP_50MS_CYC - 1);
      2'b11: step_last = 22'(STEP_100MS_CYC - 1);
    endcase
  end

  // The compare is >= so that a shorter step chosen mid-count still expires.
  assign tick = (step_cnt_ff >= step_last);

  // The step timer only runs while the code is away from its goal, so the first
  // step of a ramp that starts from rest at its goal always takes a full interval.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      step_cnt_ff <= 22'h000000;
    end else if (cur_ff == goal || tick) begin
      step_cnt_ff <= 22'h000000;
    end else begin
      step_cnt_ff <= step_cnt_ff + 22'h000001;
    end
  end

  // One code per step toward the live goal, so a new target mid-ramp is followed.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff <= 5'h00;
    end else if (tick && cur_ff < goal) begin
      cur_ff <= cur_ff + 5'h01;
    end else if (tick && cur_ff > goal) begin
      cur_ff <= cur_ff - 5'h01;
    end
  end

  // Main sinks stay lit after disable until the ramp has come back down to code 0.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      main_active_ff <= 1'b0;
    end else begin
      main_active_ff <= main_on | (main_active_ff & (cur_ff != 5'h00));
    end
  end

  always_comb begin
    nxt_drive = '0;
    nxt_drive.sink_on[3:0] = {4{main_active_ff}};
    nxt_drive.sink_on[4] = gp_ff[`GP_SEC_ON];
    nxt_drive.sink_on[5] = ~gp_ff[`GP_SD_ONE] &
      (gp_ff[`GP_ONE_MAIN] ? main_active_ff : gp_ff[`GP_SEC_ON]);
    nxt_drive.sink_on[6] = ~gp_ff[`GP_SD_TWO] &
      (gp_ff[`GP_TWO_MAIN] ? main_active_ff : gp_ff[`GP_SEC_ON]);
    nxt_drive.sink_on[7] = gp_ff[`GP_IND_ON];
    nxt_drive.assign_in_main = {gp_ff[`GP_TWO_MAIN], gp_ff[`GP_ONE_MAIN]};
    nxt_drive.main_code = cur_ff;
    nxt_drive.sec_code = sec_ff;
    nxt_drive.ind_code = ind_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_ff <= '0;
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign drive = drive_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_step_up;
    tick && (cur_ff < goal);
  endsequence

  sequence s_step_down;
    tick && (cur_ff > goal);
  endsequence

  property p_ramp_up;
    s_step_up |=> cur_ff == $past(cur_ff) + 5'h01;
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("Ramp up step not one.");

  property p_ramp_down;
    s_step_down |=> cur_ff == $past(cur_ff) - 5'h01;
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("Ramp down step not one.");

  property p_no_jump;
    $changed(cur_ff) |-> $past(tick);
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("Code moved without a step.");

  // Cycles since the code last moved while away from its goal, at the shortest step only.
  // A counter is used because the step is far longer than a delay range may reach.
  logic [4:0] cur_q_ff;
  logic [21:0] stall_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_q_ff <= 5'h00;
      stall_ff <= 22'h000000;
    end else begin
      cur_q_ff <= cur_ff;
      if (rs_ff != 2'b00 || cur_ff == goal || cur_ff != cur_q_ff) begin
        stall_ff <= 22'h000000;
      end else begin
        stall_ff <= stall_ff + 22'h000001;
      end
    end
  end

  property p_fast_step;
    (rs_ff == 2'b00) |-> (stall_ff <= 22'(STEP_100US_CYC));
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("Short step too slow.");

  property p_target_write;
    (wr.valid && wr.addr == `REG_MAIN_LEVEL) |=> tgt_ff == $past(wr.data[4:0]);
  endproperty
  a_target_write: assert property (p_target_write) else $error("Target not stored.");

  property p_ind_one;
    1'b1 |=> drive.sink_on[7] == $past(gp_ff[`GP_IND_ON]);
  endproperty
  a_ind_one: assert property (p_ind_one) else $error("Indicator sink wrong.");

  property p_sd_one;
    $past(gp_ff[`GP_SD_ONE]) |-> !drive.sink_on[5];
  endproperty
  a_sd_one: assert property (p_sd_one) else $error("Shut sink is lit.");

  property p_assign_one;
    ($past(gp_ff[`GP_ONE_MAIN]) && !$past(gp_ff[`GP_SD_ONE]))
      |-> drive.sink_on[5] == $past(main_active_ff);
  endproperty
  a_assign_one: assert property (p_assign_one) else $error("Sink not in main.");

  property p_sec_direct;
    1'b1 |=> drive.sec_code == $past(sec_ff);
  endproperty
  a_sec_direct: assert property (p_sec_direct) else $error("Secondary not direct.");

  property p_main_on;
    main_on |=> main_active_ff ##1 drive.sink_on[3:0] == 4'hF;
  endproperty
  a_main_on: assert property (p_main_on) else $error("Main sinks not lit.");

endmodule
`default_nettype wire

// ---- design/serial_reg_port.sv ----
// Two-wire serial slave that turns bus writes into register write strobes.
`include "led_ctrl_regs.svh"
`default_nettype none
module serial_reg_port
  import led_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe,
  output reg_wr_t wr,
  output logic [7:0] rd_ptr,
  input wire logic [7:0] rd_data
);

  logic [2:0] scl_s_ff;
  logic [2:0] sda_s_ff;
  logic scl_f_ff;
  logic sda_f_ff;
  logic scl_p_ff;
  logic sda_p_ff;
  port_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] rd_sh_ff;
  logic [7:0] ptr_ff;
  logic oe_ff;
  logic rw_ff;
  logic mack_ff;
  reg_wr_t wr_ff;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // A pin level is accepted only once the second and third stages agree.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_s_ff <= 3'h7;
      sda_s_ff <= 3'h7;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      scl_p_ff <= 1'b1;
      sda_p_ff <= 1'b1;
    end else begin
      scl_s_ff <= {scl_s_ff[1:0], scl};
      sda_s_ff <= {sda_s_ff[1:0], sda_in};
      scl_f_ff <= (scl_s_ff[1] == scl_s_ff[2]) ? scl_s_ff[2] : scl_f_ff;
      sda_f_ff <= (sda_s_ff[1] == sda_s_ff[2]) ? sda_s_ff[2] : sda_f_ff;
      scl_p_ff <= scl_f_ff;
      sda_p_ff <= sda_f_ff;
    end
  end

  assign rise = scl_f_ff & ~scl_p_ff;
  assign fall = ~scl_f_ff & scl_p_ff;
  assign start = scl_f_ff & scl_p_ff & sda_p_ff & ~sda_f_ff;
  assign stop = scl_f_ff & scl_p_ff & ~sda_p_ff & sda_f_ff;

  // Bits are counted on clock rises; the slave only moves its data line on falls.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= PS_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rd_sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      wr_ff <= '0;
    end else begin
      wr_ff.valid <= 1'b0;
      if (start) begin
        state_ff <= PS_DEV;
        cnt_ff <= 4'h0;
        oe_ff <= 1'b0;
      end else if (stop) begin
        state_ff <= PS_IDLE;
        oe_ff <= 1'b0;
      end else if (state_ff != PS_IDLE && rise) begin
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff < 4'h8) begin
          sh_ff <= {sh_ff[6:0], sda_f_ff};
        end else begin
          mack_ff <= ~sda_f_ff;
        end
      end else if (state_ff != PS_IDLE && fall) begin
        if (cnt_ff == 4'h8) begin
          unique case (state_ff)
            PS_DEV: begin
              rw_ff <= sh_ff[0];
              oe_ff <= (sh_ff[7:1] == DEV_ADDR);
            end
            PS_PTR: begin
              ptr_ff <= sh_ff;
              oe_ff <= 1'b1;
            end
            PS_WDATA: begin
              wr_ff <= '{valid: 1'b1, addr: ptr_ff, data: sh_ff};
              oe_ff <= 1'b1;
            end
            default: begin
              oe_ff <= 1'b0;
            end
          endcase
        end else if (cnt_ff == 4'h9) begin
          cnt_ff <= 4'h0;
          oe_ff <= 1'b0;
          unique case (state_ff)
            PS_DEV: begin
              if (!oe_ff) begin
                state_ff <= PS_IDLE;
              end else if (rw_ff) begin
                state_ff <= PS_RDATA;
                rd_sh_ff <= rd_data;
                oe_ff <= ~rd_data[7];
              end else begin
                state_ff <= PS_PTR;
              end
            end
            PS_PTR: begin
              state_ff <= PS_WDATA;
            end
            PS_RDATA: begin
              if (mack_ff) begin
                rd_sh_ff <= rd_data;
                oe_ff <= ~rd_data[7];
              end else begin
                state_ff <= PS_IDLE;
              end
            end
            default: begin
            end
          endcase
        end else if (state_ff == PS_RDATA && cnt_ff != 4'h0) begin
          oe_ff <= ~rd_sh_ff[3'(4'h7 - cnt_ff)];
        end
      end
    end
  end

  assign sda_oe = oe_ff;
  assign wr = wr_ff;
  assign rd_ptr = ptr_ff;

endmodule
`default_nettype wire

// ---- tb/led_group_assign_ramp_ctrl_bench.sv ----
// Self-checking bench for LED grouping, brightness registers and the main group ramp.
`include "led_ctrl_regs.svh"
`default_nettype none
module led_group_assign_ramp_ctrl_bench
  import led_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP0 = `STEP_100US_CYC;
  localparam int STEP1 = 40;
  localparam int STEP2 = 60;
  localparam int STEP3 = 80;
  localparam logic [7:0] PTRS [6] = '{8'h10, 8'hA0, 8'hB0, 8'hC0, 8'h20, 8'h60};
  localparam logic [7:0] VALS [6] = '{`RST_GENERAL, `RST_MAIN_LEVEL, `RST_SEC_LEVEL,
                                      `RST_IND_LEVEL, `RST_RAMP_STEP, `RST_VF_DELAY};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic sda_line;
  sink_drive_t drive;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int step_cyc = 0;
  int gap = 0;
  int n_chg = 0;
  logic armed = 1'b0;
  logic [4:0] last_code = 5'h00;
  logic [7:0] rd;
  logic [2:0] acks;
  // The data line has a pull-up, so a released line reads high.
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  always #25 mclk = ~mclk;
  led_group_assign_ramp_ctrl #(
    .STEP_25MS_CYC(STEP1),
    .STEP_50MS_CYC(STEP2),
    .STEP_100MS_CYC(STEP3)
  ) u_dut (
    .mclk(mclk),
    .rst(rst),
    .scl(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .drive(drive)
  );
  serial_host_model u_host (
    .mclk(mclk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_pull(sda_pull)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    u_host.write_reg(`DEV_ADDR, ptr, d, acks);
    check("ack", 16'(acks), 16'h0007);
  endtask
  task automatic rdc(input logic [7:0] ptr, input logic [7:0] exp);
    u_host.read_reg(ptr, rd);
    check($sformatf("reg_%h", ptr), 16'(rd), 16'(exp));
  endtask
  task automatic wait_code(input logic [4:0] c, input int lim);
    int k;
    k = 0;
    while (drive.main_code !== c && k < lim) begin
      @(posedge mclk);
      k++;
    end
    check("main_code", 16'(drive.main_code), 16'(c));
  endtask
  // Every code change is one step, and changes inside one ramp are one interval apart.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    gap <= gap + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      finish_test();
    end
    if (!rst && drive.main_code !== last_code) begin
      check("main_step", {15'h0000, (drive.main_code == last_code + 5'h01) ||
            (drive.main_code == last_code - 5'h01)}, 16'h0001);
      if (armed && step_cyc != 0) begin
        check("step_gap", 16'(gap), 16'(step_cyc));
      end
      gap <= 1;
      armed <= 1'b1;
      n_chg <= n_chg + 1;
      last_code <= drive.main_code;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    check("sink_on", 16'(drive.sink_on), 16'h0000);
    check("assign", 16'(drive.assign_in_main), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      rdc(PTRS[i], VALS[i]);
    end
    rdc(8'h33, 8'h00);
    u_host.write_reg(7'h37, 8'h10, 8'h01, acks);
    check("nack", 16'(acks), 16'h0000);
    rdc(8'h10, 8'h00);
    wr(8'hB0, 8'h05);
    wr(8'hC0, 8'h07);
    wr(8'h10, 8'h06);
    check("sec_code", 16'(drive.sec_code), 16'h0005);
    check("ind_code", 16'(drive.ind_code), 16'h0007);
    check("sink_on", 16'(drive.sink_on), 16'h00F0);
    rdc(8'hB0, 8'hFD);
    wr(8'h10, 8'h66);
    check("assign", 16'(drive.assign_in_main), 16'h0003);
    check("sink_on", 16'(drive.sink_on), 16'h0090);
    wr(8'h10, 8'h1E);
    check("sink_on", 16'(drive.sink_on), 16'h0090);
    rdc(8'h10, 8'h1E);
    // Unused secondary and indicator enables are left cleared from here on.
    wr(8'h10, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'hA0, 8'h02);
    step_cyc = STEP0;
    armed = 1'b0;
    wr(8'h10, 8'h01);
    check("sink_on", 16'(drive.sink_on), 16'h000F);
    wait_code(5'h02, 3 * STEP0 + 100);
    wr(8'h20, 8'h03);
    step_cyc = STEP3;
    armed = 1'b0;
    wr(8'hA0, 8'h3F);
    wr(8'h10, 8'h61);
    rdc(8'h20, 8'hF7);
    wait_code(5'h1F, 32 * STEP3);
    check("sink_on", 16'(drive.sink_on), 16'h006F);
    rdc(8'h20, 8'hF3);
    rdc(8'hA0, 8'hFF);
    wr(8'h10, 8'h69);
    check("sink_on", 16'(drive.sink_on), 16'h004F);
    wr(8'h20, 8'h02);
    step_cyc = STEP2;
    armed = 1'b0;
    wr(8'hA0, 8'h04);
    // The retarget may restart the step timer, so intervals across it are not judged.
    step_cyc = 0;
    wr(8'hA0, 8'h10);
    armed = 1'b0;
    step_cyc = STEP2;
    wait_code(5'h10, 20 * STEP2);
    repeat (3 * STEP2) @(posedge mclk);
    check("main_hold", 16'(drive.main_code), 16'h0010);
    wr(8'h20, 8'h01);
    step_cyc = STEP1;
    armed = 1'b0;
    wr(8'h10, 8'h60);
    check("sink_on", 16'(drive.sink_on), 16'h006F);
    wait_code(5'h00, 20 * STEP1);
    repeat (4) @(posedge mclk);
    check("sink_on", 16'(drive.sink_on), 16'h0000);
    check("n_chg", 16'(n_chg), 16'd62);
    finish_test();
  end
endmodule
`default_nettype wire

// ---- tb/serial_host_model.sv ----
// Two-wire serial bus master model that writes and reads the LED control registers.
`include "led_ctrl_regs.svh"
`default_nettype none
module serial_host_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Eight clocks a quarter bit leave room for the slave's synchroniser and filter.
  task automatic quarter();
    repeat (8) @(posedge mclk);
  endtask
  task automatic send_bit(input logic b);
    sda_pull <= ~b;
    quarter();
    scl <= 1'b1;
    quarter();
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic take_bit(output logic b);
    sda_pull <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    b = sda_line;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic begin_frame();
    sda_pull <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic end_frame();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b0;
    quarter();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    take_bit(b);
    ack = (b === 1'b0);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                           output logic [2:0] acks);
    begin_frame();
    send_byte({dev, 1'b0}, acks[2]);
    send_byte(ptr, acks[1]);
    send_byte(d, acks[0]);
    end_frame();
  endtask
  // The pointer is set by a write frame, then a repeated start turns the bus round.
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    begin_frame();
    send_byte({`DEV_ADDR, 1'b0}, a);
    send_byte(ptr, a);
    begin_frame();
    send_byte({`DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      take_bit(d[i]);
    end
    send_bit(1'b1);
    end_frame();
  endtask
endmodule
`default_nettype wire
